// >>> timer_status_pkg.sv
package timer_status_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 3;

  // byte offsets of the register words
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 8'h0C;

  // layout of compare_capture_status_a
  localparam logic [7:0] STATUS_INIT = 8'h88;
  localparam int FLAG_LSB = 0;
  localparam int ENABLE_LSB = 4;
  localparam int RSVD_HI = 7;
  localparam int RSVD_LO = 3;
  localparam logic [NUM_CH-1:0] EVT_INIT = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_STATUS,
    SEL_EVT_STATUS,
    SEL_EVT_CLEAR,
    SEL_EVT_ENABLE,
    SEL_NONE
  } sel_t;

  // word decode; the low two address bits are ignored
  function automatic sel_t decodeSel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'h0};
    if (w == OFS_STATUS) return SEL_STATUS;
    if (w == OFS_EVT_STATUS) return SEL_EVT_STATUS;
    if (w == OFS_EVT_CLEAR) return SEL_EVT_CLEAR;
    if (w == OFS_EVT_ENABLE) return SEL_EVT_ENABLE;
    return SEL_NONE;
  endfunction : decodeSel

endpackage : timer_status_pkg

// >>> compare_flag_cell.sv
`timescale 1ns/1ps
module compare_flag_cell import timer_status_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic init,
  input wire logic setEvt,
  input wire logic swClear,
  input wire logic dmaClear,
  output logic flag,
  output logic overrun
);

  logic flag_r;
  logic flag_nxt;

  // a set in the same cycle as either clear wins
  assign flag_nxt = setEvt | (flag_r & ~swClear & ~dmaClear);

  always_ff @(posedge clk) begin
    if (srst || init) begin
      flag_r <= STATUS_INIT[FLAG_LSB];
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;
  assign overrun = setEvt & flag_r;

  property p_set_wins;
    @(posedge clk) disable iff (srst || init)
      setEvt && (swClear || dmaClear) |=> flag_r;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag lost a set that met a clear");

  property p_dma_clear;
    @(posedge clk) disable iff (srst || init)
      dmaClear && !setEvt |=> !flag_r;
  endproperty
  a_dma_clear: assert property (p_dma_clear)
    else $error("dma transfer did not clear the flag");

endmodule : compare_flag_cell

// >>> timer_compare_status_a.sv
`timescale 1ns/1ps
module timer_compare_status_a import timer_status_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic standby,
  input wire logic [CNT_W-1:0] ch0Counter,
  input wire logic [CNT_W-1:0] ch1Counter,
  input wire logic [CNT_W-1:0] ch2Counter,
  input wire logic [CNT_W-1:0] ch0GeneralRegA,
  input wire logic [CNT_W-1:0] ch1GeneralRegA,
  input wire logic [CNT_W-1:0] ch2GeneralRegA,
  input wire logic [NUM_CH-1:0] captureMode,
  input wire logic [NUM_CH-1:0] captureStrobe,
  input wire logic [NUM_CH-1:0] dmaAck,
  output logic ch0MatchIrq,
  output logic ch1MatchIrq,
  output logic ch2MatchIrq,
  output logic irqOut,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp
);

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 1 and 32");
  end

  // compare and capture events
  logic [CNT_W-1:0] cnt [NUM_CH];
  logic [CNT_W-1:0] gra [NUM_CH];
  logic [NUM_CH-1:0] matchNow;
  logic [NUM_CH-1:0] matchPrev_r;
  logic [NUM_CH-1:0] setEvt;
  logic [NUM_CH-1:0] flags;
  logic [NUM_CH-1:0] overrun;
  logic [NUM_CH-1:0] swClear;
  logic [NUM_CH-1:0] armed_r;
  logic [NUM_CH-1:0] armed_nxt;
  logic [NUM_CH-1:0] readArm;
  logic [NUM_CH-1:0] en_r;
  logic [NUM_CH-1:0] chIrq_r;
  logic [NUM_CH-1:0] evtStatus_r;
  logic [NUM_CH-1:0] evtEn_r;
  logic [NUM_CH-1:0] evtClr;
  logic irq_r;
  logic initNow;
  logic [7:0] statusValue;

  assign cnt[0] = ch0Counter;
  assign cnt[1] = ch1Counter;
  assign cnt[2] = ch2Counter;
  assign gra[0] = ch0GeneralRegA;
  assign gra[1] = ch1GeneralRegA;
  assign gra[2] = ch2GeneralRegA;
  assign initNow = srst | standby;

  // bus side
  logic awready_r;
  logic wready_r;
  logic awHeld_r;
  logic wHeld_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [DATA_W-1:0] wData_r;
  logic [3:0] wStrb_r;
  logic arready_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;
  logic awTake;
  logic wTake;
  logic doWrite;
  logic awHeld_nxt;
  logic wHeld_nxt;
  logic bvalid_nxt;
  logic arTake;
  logic rvalid_nxt;
  logic statusWr;
  sel_t wSel;
  sel_t rSel;
  logic [7:0] readValue;

  // phase counting on channel 2 only changes how its counter moves, so
  // only captureMode gates the event logic of a channel
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign matchNow[i] = ~captureMode[i] & (cnt[i] == gra[i]);
    // edge of the match so a counter that dwells on the value sets once
    assign setEvt[i] = (matchNow[i] & ~matchPrev_r[i])
      | (captureMode[i] & captureStrobe[i]);
    assign swClear[i] = statusWr & ~wData_r[FLAG_LSB + i]
      & armed_r[i];

    compare_flag_cell u_flag (
      .clk(clk),
      .srst(srst),
      .init(standby),
      .setEvt(setEvt[i]),
      .swClear(swClear[i]),
      .dmaClear(dmaAck[i]),
      .flag(flags[i]),
      .overrun(overrun[i])
    );
  end

  assign statusValue = {STATUS_INIT[RSVD_HI], en_r,
    STATUS_INIT[RSVD_LO], flags};

  // write channel
  assign awTake = awvalid & awready_r;
  assign wTake = wvalid & wready_r;
  assign doWrite = awHeld_r & wHeld_r & ~bvalid_r;
  assign awHeld_nxt = (awHeld_r | awTake) & ~doWrite;
  assign wHeld_nxt = (wHeld_r | wTake) & ~doWrite;
  assign bvalid_nxt = doWrite | (bvalid_r & ~bready);
  assign wSel = decodeSel(awAddr_r);
  assign statusWr = doWrite & (wSel == SEL_STATUS) & wStrb_r[0];
  assign evtClr = (doWrite && wSel == SEL_EVT_CLEAR && wStrb_r[0]) ?
    wData_r[NUM_CH-1:0] : '0;

  always_ff @(posedge clk) begin
    if (srst) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else begin
      awready_r <= ~awHeld_nxt & ~bvalid_nxt;
      wready_r <= ~wHeld_nxt & ~bvalid_nxt;
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      bvalid_r <= bvalid_nxt;
      if (awTake) begin
        awAddr_r <= awaddr;
      end
      if (wTake) begin
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (doWrite) begin
        bresp_r <= (wSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // read channel
  assign arTake = arvalid & arready_r;
  assign rvalid_nxt = arTake | (rvalid_r & ~rready);
  assign rSel = decodeSel(araddr);
  assign readValue = (rSel == SEL_STATUS) ? statusValue :
    (rSel == SEL_EVT_STATUS) ? {5'h00, evtStatus_r} :
    (rSel == SEL_EVT_ENABLE) ? {5'h00, evtEn_r} : 8'h00;

  always_ff @(posedge clk) begin
    if (srst) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (arTake) begin
        rdata_r <= {24'h000000, readValue};
        rresp_r <= (rSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // a flag read as 1 arms its clear; any status write with byte 0 strobed disarms all
  assign readArm = {NUM_CH{arTake && rSel == SEL_STATUS}} & flags;
  assign armed_nxt = (armed_r | readArm) & flags & ~{NUM_CH{statusWr}};

  always_ff @(posedge clk) begin
    if (initNow) begin
      armed_r <= '0;
      en_r <= STATUS_INIT[ENABLE_LSB +: NUM_CH];
    end else begin
      armed_r <= armed_nxt;
      if (statusWr) begin
        en_r <= wData_r[ENABLE_LSB +: NUM_CH];
      end
    end
  end

  // outputs lag the flag by one clock so they come from flip-flops
  always_ff @(posedge clk) begin
    if (initNow) begin
      chIrq_r <= '0;
    end else begin
      chIrq_r <= flags & en_r;
    end
  end

  // sticky record of a set that met an already set flag
  always_ff @(posedge clk) begin
    if (srst) begin
      evtStatus_r <= EVT_INIT;
      evtEn_r <= EVT_INIT;
      irq_r <= 1'b0;
      matchPrev_r <= '0;
    end else begin
      matchPrev_r <= matchNow;
      evtStatus_r <= overrun | (evtStatus_r & ~evtClr);
      if (doWrite && wSel == SEL_EVT_ENABLE && wStrb_r[0]) begin
        evtEn_r <= wData_r[NUM_CH-1:0];
      end
      irq_r <= |(evtStatus_r & evtEn_r);
    end
  end

  assign ch0MatchIrq = chIrq_r[0];
  assign ch1MatchIrq = chIrq_r[1];
  assign ch2MatchIrq = chIrq_r[2];
  assign irqOut = irq_r;
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_init_value;
    $past(srst) || $past(standby) |-> statusValue == STATUS_INIT;
  endproperty
  a_init_value: assert property (p_init_value)
    else $error("register not at its initial value after init");

  property p_reserved;
    arTake && rSel == SEL_STATUS |=>
      rdata[RSVD_HI] && rdata[RSVD_LO];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit changed by a write");

  property p_one_keeps;
    statusWr && wData_r[1] && flags[1] && !dmaAck[1] && !standby |=> flags[1];
  endproperty
  a_one_keeps: assert property (p_one_keeps)
    else $error("writing 1 changed a flag");

  property p_irq2;
    flags[2] && en_r[2] && !standby |=> ch2MatchIrq;
  endproperty
  a_irq2: assert property (p_irq2)
    else $error("channel 2 request missing");

  property p_irq1_off;
    !en_r[1] |=> !ch1MatchIrq;
  endproperty
  a_irq1_off: assert property (p_irq1_off)
    else $error("channel 1 request while disabled");

  property p_irq0;
    flags[0] && en_r[0] && !standby |=> ch0MatchIrq ##1 1'b1;
  endproperty
  a_irq0: assert property (p_irq0)
    else $error("channel 0 request missing");

  property p_compare_sets;
    $rose(matchNow[0]) && !standby |=> flags[0];
  endproperty
  a_compare_sets: assert property (p_compare_sets)
    else $error("compare match did not set the flag");

  property p_capture_sets;
    captureMode[2] && captureStrobe[2] && !standby |=> flags[2];
  endproperty
  a_capture_sets: assert property (p_capture_sets)
    else $error("capture did not set the flag");

  property p_unread_keeps;
    statusWr && !wData_r[0] && !armed_r[0] && flags[0] && !dmaAck[0]
      && !standby |=> flags[0];
  endproperty
  a_unread_keeps: assert property (p_unread_keeps)
    else $error("flag cleared without a prior read");

  property p_read_clear;
    statusWr && !wData_r[1] && armed_r[1] && !setEvt[1] |=> !flags[1];
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read then write 0 did not clear the flag");

  property p_evt_irq;
    |(evtStatus_r & evtEn_r) |=> irqOut;
  endproperty
  a_evt_irq: assert property (p_evt_irq)
    else $error("enabled event did not raise the interrupt");

  c_sw_clear: cover property (swClear[0] ##1 !flags[0]);
  c_dma_clear: cover property (dmaAck[2] && flags[2] ##1 !flags[2]);
  c_set_meets_clear: cover property (setEvt[2] && dmaAck[2]);
  c_evt_irq: cover property ($rose(irqOut));

endmodule : timer_compare_status_a

// >>> dma_partner.sv
`timescale 1ns/1ps
module dma_partner (
  input wire logic clk,
  input wire logic srst,
  input wire logic autoEn,
  input wire logic [2:0] manReq,
  input wire logic [2:0] irqIn,
  output logic [2:0] dmaAck
);
  logic [2:0] ackPend_r;
  logic [2:0] ackPend_nxt;
  // a transfer on every other cycle while a request is high; it waits a cycle, like a real arbiter
  assign ackPend_nxt = autoEn ? (irqIn & ~ackPend_r) : 3'h0;
  always_ff @(posedge clk) begin
    if (srst) ackPend_r <= 3'h0;
    else ackPend_r <= ackPend_nxt;
  end
  assign dmaAck = ackPend_r | manReq;
endmodule : dma_partner

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin failures++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb_top import timer_status_pkg::*;;
  logic clk, srst, standby, awvalid, wvalid, bready, arvalid, rready, autoEn;
  logic [15:0] c0, c1, c2, g0, g1, g2;
  logic [2:0] captureMode, captureStrobe, dmaAck, manReq, awprot, arprot;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, irqOut;
  logic ch0MatchIrq, ch1MatchIrq, ch2MatchIrq;
  logic [2:0] irqV;
  logic [31:0] rd;
  int failures, nTests;
  assign irqV = {ch2MatchIrq, ch1MatchIrq, ch0MatchIrq};

  timer_compare_status_a #(.CNT_W(16)) timer_compare_status_a_inst (
    .clk(clk), .srst(srst), .standby(standby),
    .ch0Counter(c0), .ch1Counter(c1), .ch2Counter(c2),
    .ch0GeneralRegA(g0), .ch1GeneralRegA(g1), .ch2GeneralRegA(g2),
    .captureMode(captureMode), .captureStrobe(captureStrobe),
    .dmaAck(dmaAck), .ch0MatchIrq(ch0MatchIrq), .ch1MatchIrq(ch1MatchIrq),
    .ch2MatchIrq(ch2MatchIrq), .irqOut(irqOut),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  dma_partner dma_partner_inst (.clk(clk), .srst(srst), .autoEn(autoEn),
    .manReq(manReq), .irqIn(irqV), .dmaAck(dmaAck));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic axiWr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 50) failures++;
    // let an edge pass so a following call never re-raises bready at once
    @(posedge clk);
  endtask : axiWr

  task automatic axiRd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 50) failures++;
    @(posedge clk);
  endtask : axiRd

  task automatic capPulse(input logic [2:0] m);
    captureStrobe <= m;
    @(posedge clk);
    captureStrobe <= 3'h0;
    cyc(2);
  endtask : capPulse

  task automatic tResetValues;
    axiRd(OFS_STATUS);
    `CHK("status", 32'h00000088, rd)
    wstrb <= 4'hE;
    axiWr(OFS_STATUS, 8'hF8);
    wstrb <= 4'hF;
    `CHK("wrResp", RESP_OKAY, resp)
    axiRd(OFS_STATUS);
    `CHK("status", 32'h00000088, rd)
    axiWr(OFS_STATUS, 8'hFF);
    axiRd(OFS_STATUS);
    `CHK("status", 32'h000000F8, rd)
    `CHK("irqs", 3'h0, irqV)
    axiWr(OFS_STATUS, 8'h08);
    axiRd(OFS_STATUS);
    `CHK("status", 32'h00000088, rd)
    $display("done reset values");
  endtask : tResetValues

  task automatic tCompareClear;
    g0 <= 16'h0005;
    for (int k = 0; k < 8; k++) begin
      c0 <= k[15:0];
      @(posedge clk);
    end
    cyc(2);
    // a write before any read of the set flag must not clear it
    axiWr(OFS_STATUS, 8'h88);
    axiRd(OFS_STATUS);
    `CHK("status", 32'h00000089, rd)
    axiWr(OFS_STATUS, 8'h88);
    axiRd(OFS_STATUS);
    `CHK("status", 32'h00000088, rd)
    $display("done compare and clear");
  endtask : tCompareClear

  task automatic tIrqEnables;
    logic [7:0] en;
    captureMode <= 3'h7;
    for (int i = 0; i < 3; i++) begin
      en = 8'h10 << i;
      capPulse(3'h1 << i);
      cyc(2);
      `CHK("irqs", 3'h0, irqV)
      axiWr(OFS_STATUS, 8'h88 | en | (8'h07 & ~(8'h01 << i)));
      cyc(2);
      `CHK("irqs", 3'h1 << i, irqV)
      autoEn <= 1'b1;
      cyc(6);
      autoEn <= 1'b0;
      cyc(2);
      `CHK("irqs", 3'h0, irqV)
      axiRd(OFS_STATUS);
      `CHK("status", {24'h000000, 8'h88 | en}, rd)
    end
    axiWr(OFS_STATUS, 8'h88);
    $display("done irq enables");
  endtask : tIrqEnables

  task automatic tSetWins;
    captureStrobe <= 3'h4;
    manReq <= 3'h4;
    @(posedge clk);
    captureStrobe <= 3'h0;
    manReq <= 3'h0;
    cyc(2);
    axiRd(OFS_STATUS);
    `CHK("status", 32'h0000008C, rd)
    axiWr(OFS_STATUS, 8'h88);
    axiRd(OFS_STATUS);
    `CHK("status", 32'h00000088, rd)
    $display("done set beats clear");
  endtask : tSetWins

  task automatic tEvents;
    capPulse(3'h2);
    capPulse(3'h2);
    cyc(2);
    `CHK("irqOut", 1'b0, irqOut)
    axiRd(OFS_EVT_STATUS);
    `CHK("evtStatus", 32'h00000002, rd)
    axiWr(OFS_EVT_ENABLE, 8'h02);
    cyc(2);
    `CHK("irqOut", 1'b1, irqOut)
    axiWr(OFS_EVT_CLEAR, 8'h02);
    cyc(2);
    `CHK("irqOut", 1'b0, irqOut)
    axiWr(8'h40, 8'h00);
    `CHK("wrResp", RESP_SLVERR, resp)
    axiRd(8'h40);
    `CHK("rdResp", RESP_SLVERR, resp)
    `CHK("rdData", 32'h00000000, rd)
    manReq <= 3'h2;
    @(posedge clk);
    manReq <= 3'h0;
    cyc(2);
    axiRd(OFS_STATUS);
    `CHK("status", 32'h00000088, rd)
    $display("done event interrupt");
  endtask : tEvents

  task automatic tStandby;
    axiWr(OFS_STATUS, 8'hF8);
    capPulse(3'h1);
    standby <= 1'b1;
    cyc(2);
    standby <= 1'b0;
    cyc(1);
    axiRd(OFS_STATUS);
    `CHK("status", 32'h00000088, rd)
    `CHK("irqs", 3'h0, irqV)
    $display("done standby");
  endtask : tStandby

  initial begin
    failures = 0;
    nTests = 0;
    srst = 1'b1;
    standby = 1'b0;
    {c0, c1, c2} = '0;
    // compare registers start away from the counters to avoid a false match
    {g0, g1, g2} = {3{16'hFFFF}};
    captureMode = 3'h0;
    captureStrobe = 3'h0;
    manReq = 3'h0;
    autoEn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    awprot = 3'h0;
    arprot = 3'h0;
    cyc(10);
    srst <= 1'b0;
    cyc(2);
    tResetValues();
    tCompareClear();
    tIrqEnables();
    tSetWins();
    tEvents();
    tStandby();
    end_of_test();
  end

  initial begin
    cyc(5000);
    failures++;
    end_of_test();
  end
endmodule : tb_top
